// *** hw/etxcs_top.sv ***
/*
 * Transmit control and status of a 10 Mb/s MAC with its banked register
 * selector. Assumes a serial core that reports carrier, collision, end of
 * frame and the transceiver quality signal synchronous to mclk_i, and a
 * buffer manager that stores the status word pulsed out after each frame.
 */
`timescale 1ns/1ps
`include "etxcs_regs.svh"
module etxcs_top #(
    parameter logic [17:0] LATE_COL_CYC =
        18'(`ETXCS_LATE_COL_BYTES * `ETXCS_BYTE_NS / `ETXCS_CLK_NS),
    parameter logic [17:0] EXCESSIVE_DEFERRAL_CYC =
        18'(`ETXCS_EXCESSIVE_DEFERRAL_BYTES * `ETXCS_BYTE_NS / `ETXCS_CLK_NS)
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire etxcs_pkg::etxcs_bus_s bus_i,
    input wire etxcs_pkg::etxcs_ev_s ev_i,
    input wire logic link_event_enable_i,
    input wire logic config_soft_reset_i,
    output logic [15:0] rdata_o,
    output etxcs_pkg::etxcs_mode_s mode_o,
    output logic transmit_enable_o,
    output logic tx_go_o,
    output logic jam_o,
    output logic abort_o,
    output logic status_wb_o,
    output logic [15:0] status_word_o,
    output logic mac_core_interrupt_o,
    output logic link_int_o
);
    // ********************************************
    // Cycle counts derived from the printed times
    // ********************************************
    localparam logic [17:0] IFG_CYC = 18'(`ETXCS_CYC(`ETXCS_IFG_NS));
    localparam logic [17:0] DEFR_WIN_CYC = 18'(`ETXCS_CYC(`ETXCS_DEFR_WIN_NS));
    localparam logic [17:0] PRE_CYC = 18'(`ETXCS_CYC(`ETXCS_PREAMBLE_NS));
    localparam logic [17:0] GAP_CYC = 18'(`ETXCS_CYC(`ETXCS_SQE_GAP_NS));
    localparam logic [17:0] WIN_CYC = 18'(`ETXCS_CYC(`ETXCS_SQE_WIN_NS));
    localparam int GAP_HOLD = `ETXCS_CYC(`ETXCS_SQE_GAP_NS) - 1; // Gap cycles after the first

    etxcs_pkg::etxcs_state_s q; // Registered state
    etxcs_pkg::etxcs_state_s n; // Next state
    logic [15:0] nv; // Control word after a bus write
    logic [15:0] rv; // Read value
    logic fin; // Frame finished this cycle
    logic fatal; // Frame ended with a fatal error
    logic switched_full_duplex; // Switched full duplex
    logic core_lp; // Core loopback in force
    logic local_lp; // Local loopback in force
    logic ign; // Carrier and collision ignored
    logic hit_bank; // Access to the selector word
    logic hit0; // Banked access while bank 0 is active
    logic [3:0] inc; // Counter increments per packet

    // ********************************************
    // Next-state logic
    // ********************************************
    always_comb begin
        n = q;
        nv = q.ctl;
        rv = 16'h0000;
        fin = 1'b0;
        fatal = 1'b0;
        inc = 4'h0;
        // Pulses last one cycle
        n.go = 1'b0;
        n.jam = 1'b0;
        n.abort = 1'b0;
        n.wb = 1'b0;
        n.mac_int = 1'b0;
        n.link_int = 1'b0;
        // Effective modes; switched duplex overrides duplex and monitor
        switched_full_duplex = q.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX];
        core_lp = q.ctl[`ETXCS_CTL_CORE_LOOP];
        local_lp = q.ctl[`ETXCS_CTL_LOOP] && !core_lp;
        ign = switched_full_duplex || core_lp || local_lp;
        // Selector word answers in every bank
        hit_bank = ({bus_i.addr[3:1], 1'b0} == `ETXCS_OFF_BANK);
        hit0 = !hit_bank && (q.bank == `ETXCS_BANK0);

        // Bus reads; value is registered for the next cycle
        if (hit_bank) begin
            rv = {`ETXCS_BANK_ID, 5'h00, q.bank};
        end else if (q.bank[2]) begin
            rv = `ETXCS_NONE_RD;
        end else if (hit0) begin
            unique case ({bus_i.addr[3:1], 1'b0})
                `ETXCS_OFF_CTL: rv = q.ctl;
                `ETXCS_OFF_STAT: rv = q.stat;
                `ETXCS_OFF_CNT: rv = q.ctr;
                default: rv = 16'h0000; // Unmapped in this block
            endcase
        end
        if (bus_i.rd) begin
            n.rdata = rv;
            // Reading the counters clears them and the rollover flag
            if (hit0 && {bus_i.addr[3:1], 1'b0} == `ETXCS_OFF_CNT) begin
                n.ctr = 16'h0000;
                n.stat[`ETXCS_ST_ROL] = 1'b0;
            end
        end

        // Bus writes; a missing bank swallows them
        if (bus_i.wr) begin
            if (hit_bank && bus_i.be[0]) begin
                n.bank = bus_i.wdata[2:0];
            end else if (hit0 && {bus_i.addr[3:1], 1'b0} == `ETXCS_OFF_CTL) begin
                if (bus_i.be[0]) begin
                    nv[7:0] = bus_i.wdata[7:0];
                end
                if (bus_i.be[1]) begin
                    nv[15:8] = bus_i.wdata[15:8];
                end
                n.ctl = nv & `ETXCS_CTL_WMASK;
                // Re-enabling clears the sticky fatal flags
                if (nv[`ETXCS_CTL_TXEN] && !q.ctl[`ETXCS_CTL_TXEN]) begin
                    n.stat[`ETXCS_ST_LATE] = 1'b0;
                    n.stat[`ETXCS_ST_C16] = 1'b0;
                    n.stat[`ETXCS_ST_LOST] = 1'b0;
                    n.stat[`ETXCS_ST_SQE] = 1'b0;
                    n.stat[`ETXCS_ST_SUC] = 1'b0;
                end
            end
        end

        // Link integrity follows the transceiver; edges interrupt when link_event_enable_i is set
        n.stat[`ETXCS_ST_LINK] = ev_i.link_ok;
        if ((ev_i.link_ok != q.stat[`ETXCS_ST_LINK]) && link_event_enable_i) begin
            n.link_int = 1'b1;
        end

        // Transmit sequencer
        unique case (q.st)
            etxcs_pkg::ST_IDLE: begin
                // Clearing enable only takes effect between frames
                if (q.ctl[`ETXCS_CTL_TXEN] && ev_i.tx_req) begin
                    n.st = etxcs_pkg::ST_DEFER;
                    n.cnt = 18'h00000;
                    n.dcnt = 18'h00000;
                    n.ncol = 5'h00;
                    n.stat[`ETXCS_ST_SUC] = 1'b0;
                    n.stat[`ETXCS_ST_BRD] = ev_i.bcast;
                    n.stat[`ETXCS_ST_MULT] = ev_i.mcast;
                    // Collision flags of a good frame go away now
                    if (q.stat[`ETXCS_ST_SUC]) begin
                        n.stat[`ETXCS_ST_SCOL] = 1'b0;
                        n.stat[`ETXCS_ST_MCOL] = 1'b0;
                    end
                end
            end
            etxcs_pkg::ST_DEFER: begin
                // Carrier in the early gap restarts it; later it is ignored
                if (ev_i.carrier && !ign && !q.ctl[`ETXCS_CTL_FORCE_COLLISION]
                        && q.cnt < DEFR_WIN_CYC) begin
                    n.stat[`ETXCS_ST_DEFR] = 1'b1;
                    n.cnt = 18'h00000;
                    if (q.dcnt >= EXCESSIVE_DEFERRAL_CYC) begin
                        n.stat[`ETXCS_ST_EXC] = 1'b1;
                    end else begin
                        n.dcnt = q.dcnt + 18'h00001;
                    end
                end else if (q.cnt >= IFG_CYC - 18'h00001) begin
                    n.st = etxcs_pkg::ST_SEND;
                    n.cnt = 18'h00000;
                    n.go = 1'b1;
                end else begin
                    n.cnt = q.cnt + 18'h00001;
                end
                // Deferral time holds while carrier is off; a reached limit still flags excess
                if (q.dcnt >= EXCESSIVE_DEFERRAL_CYC && !ign) begin
                    n.stat[`ETXCS_ST_EXC] = 1'b1;
                end
            end
            etxcs_pkg::ST_SEND: begin
                // Frame timer saturates rather than wraps
                if (q.cnt != 18'h3FFFF) begin
                    n.cnt = q.cnt + 18'h00001;
                end
                if (ev_i.collision && !ign) begin
                    n.ctl[`ETXCS_CTL_FORCE_COLLISION] = 1'b0;
                    n.jam = 1'b1;
                    if (q.cnt >= LATE_COL_CYC) begin
                        n.stat[`ETXCS_ST_LATE] = 1'b1;
                        n.ctl[`ETXCS_CTL_TXEN] = 1'b0;
                        fin = 1'b1;
                        fatal = 1'b1;
                    end else begin
                        n.ncol = q.ncol + 5'h01;
                        if (q.ncol == 5'h00) begin
                            n.stat[`ETXCS_ST_SCOL] = 1'b1;
                        end else begin
                            n.stat[`ETXCS_ST_MCOL] = 1'b1;
                        end
                        if (q.ncol + 5'h01 == `ETXCS_MAX_COL) begin
                            n.stat[`ETXCS_ST_C16] = 1'b1;
                            n.ctl[`ETXCS_CTL_TXEN] = 1'b0;
                            fin = 1'b1;
                            fatal = 1'b1;
                        end else begin
                            // Retry after a fresh gap; backoff is the core's
                            n.st = etxcs_pkg::ST_DEFER;
                            n.cnt = 18'h00000;
                        end
                    end
                end else if (q.ctl[`ETXCS_CTL_MON] && !switched_full_duplex && !core_lp && !local_lp
                        && q.cnt >= PRE_CYC && !ev_i.carrier) begin
                    // Own carrier missing after preamble or dropped later
                    n.stat[`ETXCS_ST_LOST] = 1'b1;
                    n.abort = 1'b1;
                    n.ctl[`ETXCS_CTL_TXEN] = 1'b0;
                    fin = 1'b1;
                    fatal = 1'b1;
                end else if (ev_i.tx_end) begin
                    // No quality test in switched duplex or either loopback
                    if (ign) begin
                        fin = 1'b1;
                    end else begin
                        n.st = etxcs_pkg::ST_SQE_GAP;
                        n.cnt = 18'h00000;
                        n.sqe_seen = 1'b0;
                    end
                end
            end
            etxcs_pkg::ST_SQE_GAP: begin
                if (q.cnt >= GAP_CYC - 18'h00001) begin
                    n.st = etxcs_pkg::ST_SQE_WIN;
                    n.cnt = 18'h00000;
                end else begin
                    n.cnt = q.cnt + 18'h00001;
                end
            end
            etxcs_pkg::ST_SQE_WIN: begin
                n.sqe_seen = q.sqe_seen || ev_i.sqe;
                n.cnt = q.cnt + 18'h00001;
                if (q.cnt >= WIN_CYC - 18'h00001) begin
                    fin = 1'b1;
                    if (!q.sqe_seen && !ev_i.sqe) begin
                        n.stat[`ETXCS_ST_SQE] = 1'b1;
                        // Only the stop option makes the test fatal
                        if (q.ctl[`ETXCS_CTL_STOP_SQE]) begin
                            n.ctl[`ETXCS_CTL_TXEN] = 1'b0;
                            n.mac_int = 1'b1;
                            fatal = 1'b1;
                        end
                    end
                end
            end
            default: n.st = etxcs_pkg::ST_IDLE; // Recover from a bad code
        endcase

        // Completion: success flag, counters, status word copy
        if (fin) begin
            n.st = etxcs_pkg::ST_IDLE;
            n.stat[`ETXCS_ST_SUC] = !fatal;
            inc[0] = (n.ncol == 5'h01);
            inc[1] = (n.ncol > 5'h01);
            inc[2] = n.stat[`ETXCS_ST_DEFR];
            inc[3] = n.stat[`ETXCS_ST_EXC];
            // Once per packet, saturating at the top
            for (int i = 0; i < 4; i++) begin
                if (inc[i] && n.ctr[4*i +: 4] != `ETXCS_CNT_MAX) begin
                    n.ctr[4*i +: 4] = n.ctr[4*i +: 4] + 4'h1;
                end
                if (n.ctr[4*i +: 4] == `ETXCS_CNT_MAX) begin
                    n.stat[`ETXCS_ST_ROL] = 1'b1;
                end
            end
            if (n.stat[`ETXCS_ST_ROL] && !q.stat[`ETXCS_ST_ROL]) begin
                n.mac_int = 1'b1;
            end
            // The copy carries the deferral flags before they clear
            n.wb = 1'b1;
            n.wbword = n.stat;
            n.stat[`ETXCS_ST_DEFR] = 1'b0;
            n.stat[`ETXCS_ST_EXC] = 1'b0;
        end

        // Soft reset restores control, status and counter defaults; a control write can also clear core loop
        if (config_soft_reset_i) begin
            n.st = etxcs_pkg::ST_IDLE;
            n.ctl = `ETXCS_CTL_RST;
            n.stat = {1'b0, ev_i.link_ok, 14'h0000};
            n.ctr = 16'h0000;
        end

        // Mode towards the core, from the control word being stored
        n.mode.fcs = !n.ctl[`ETXCS_CTL_SUPPRESS_FCS];
        n.mode.pad = n.ctl[`ETXCS_CTL_PAD];
        n.mode.skip_defer = n.ctl[`ETXCS_CTL_FORCE_COLLISION]
            || n.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX];
        n.mode.fdx = n.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX] || n.ctl[`ETXCS_CTL_FDX];
        n.mode.accept_own = n.mode.fdx;
        n.mode.csmon = n.ctl[`ETXCS_CTL_MON] && !n.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX];
        n.mode.coldet = !(n.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX] || n.ctl[`ETXCS_CTL_CORE_LOOP]
            || n.ctl[`ETXCS_CTL_LOOP]);
        if (n.ctl[`ETXCS_CTL_CORE_LOOP]) begin
            n.mode.loop = etxcs_pkg::LP_CORE;
        end else if (n.ctl[`ETXCS_CTL_LOOP]) begin
            n.mode.loop = etxcs_pkg::LP_ENDEC;
        end else begin
            n.mode.loop = etxcs_pkg::LP_NET;
        end
        n.mode.tx_net = (n.mode.loop == etxcs_pkg::LP_NET);
    end

    // ********************************************
    // State register
    // ********************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= etxcs_pkg::ST_IDLE;
            q.mode.fcs <= 1'b1;
            q.mode.coldet <= 1'b1;
            q.mode.tx_net <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = q.rdata;
    assign mode_o = q.mode;
    assign transmit_enable_o = q.ctl[`ETXCS_CTL_TXEN];
    assign tx_go_o = q.go;
    assign jam_o = q.jam;
    assign abort_o = q.abort;
    assign status_wb_o = q.wb;
    assign status_word_o = q.wbword;
    assign mac_core_interrupt_o = q.mac_int;
    assign link_int_o = q.link_int;

    // ********************************************
    // Checks and coverage
    // ********************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    chk_bank_id_read: assert property (
        bus_i.rd && hit_bank |=> rdata_o[15:8] == `ETXCS_BANK_ID)
        else $error("selector high byte not 33h");
    chk_none_bank_write: assert property (
        bus_i.wr && !hit_bank && q.bank[2] && !config_soft_reset_i
        && q.st == etxcs_pkg::ST_IDLE |=> $stable(q.ctl))
        else $error("write to missing bank changed control");
    chk_switched_full_duplex_mode: assert property (
        q.ctl[`ETXCS_CTL_SWITCHED_FULL_DUPLEX] |-> mode_o.fdx && !mode_o.coldet && !mode_o.csmon)
        else $error("switched duplex mode not forced");
    chk_loop_prio: assert property (
        q.ctl[`ETXCS_CTL_CORE_LOOP] |-> mode_o.loop == etxcs_pkg::LP_CORE && !mode_o.tx_net)
        else $error("core loopback lost priority");
    chk_fcs_suppress: assert property (
        q.ctl[`ETXCS_CTL_SUPPRESS_FCS] != mode_o.fcs)
        else $error("FCS mode disagrees with control");
    chk_late_col: assert property (
        $rose(q.stat[`ETXCS_ST_LATE]) |-> jam_o && !transmit_enable_o && status_wb_o)
        else $error("late collision without jam and stop");
    chk_sixteen_col: assert property (
        $rose(q.stat[`ETXCS_ST_C16]) |-> !transmit_enable_o && !q.stat[`ETXCS_ST_SUC])
        else $error("sixteen collisions left transmitter on");
    chk_lost_carrier: assert property (
        $rose(q.stat[`ETXCS_ST_LOST]) |-> abort_o && !transmit_enable_o)
        else $error("lost carrier without abort");
    chk_go_clears_suc: assert property (
        tx_go_o |-> !q.stat[`ETXCS_ST_SUC])
        else $error("success set during a new frame");
    chk_sqe_window: assert property (
        q.st == etxcs_pkg::ST_SEND && ev_i.tx_end && !ign && !ev_i.collision
        && !(q.ctl[`ETXCS_CTL_MON] && q.cnt >= PRE_CYC && !ev_i.carrier)
        |=> q.st == etxcs_pkg::ST_SQE_GAP ##GAP_HOLD q.st == etxcs_pkg::ST_SQE_GAP
        ##1 q.st == etxcs_pkg::ST_SQE_WIN)
        else $error("quality window not opened after gap");
    chk_wb_clears_defr: assert property (
        status_wb_o |-> !q.stat[`ETXCS_ST_DEFR] && !q.stat[`ETXCS_ST_EXC])
        else $error("deferral flags survive packet end");

    cov_frame_ok: cover property (tx_go_o ##[1:1000] status_wb_o && status_word_o[0]);
    cov_late_col: cover property ($rose(q.stat[`ETXCS_ST_LATE]));
    cov_sqe_stop: cover property (mac_core_interrupt_o && q.stat[`ETXCS_ST_SQE]);
endmodule : etxcs_top

// *** hw/etxcs_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing constants
 * of the transmit control and status block. Assumes a 100 MHz clock.
 */
`ifndef ETXCS_REGS_SVH
`define ETXCS_REGS_SVH
// ********************************************
// Offsets within the 16-location window
// ********************************************
`define ETXCS_OFF_CTL 4'h0
`define ETXCS_OFF_STAT 4'h2
`define ETXCS_OFF_CNT 4'h6
`define ETXCS_OFF_BANK 4'hE
`define ETXCS_BANK_ID 8'h33
`define ETXCS_NONE_RD 16'h3333
`define ETXCS_BANK0 3'h0
`define ETXCS_CTL_RST 16'h0000
`define ETXCS_CTL_WMASK 16'hBD8F
// ********************************************
// Control and status bit positions
// ********************************************
`define ETXCS_CTL_SWITCHED_FULL_DUPLEX 15
`define ETXCS_CTL_CORE_LOOP 13
`define ETXCS_CTL_STOP_SQE 12
`define ETXCS_CTL_FDX 11
`define ETXCS_CTL_MON 10
`define ETXCS_CTL_SUPPRESS_FCS 8
`define ETXCS_CTL_PAD 7
`define ETXCS_CTL_FORCE_COLLISION 2
`define ETXCS_CTL_LOOP 1
`define ETXCS_CTL_TXEN 0
`define ETXCS_ST_LINK 14
`define ETXCS_ST_ROL 12
`define ETXCS_ST_EXC 11
`define ETXCS_ST_LOST 10
`define ETXCS_ST_LATE 9
`define ETXCS_ST_DEFR 7
`define ETXCS_ST_BRD 6
`define ETXCS_ST_SQE 5
`define ETXCS_ST_C16 4
`define ETXCS_ST_MULT 3
`define ETXCS_ST_MCOL 2
`define ETXCS_ST_SCOL 1
`define ETXCS_ST_SUC 0
// ********************************************
// Timing, in nanoseconds, bytes and counts
// ********************************************
`define ETXCS_CLK_NS 10
`define ETXCS_BYTE_NS 800
`define ETXCS_IFG_NS 9600
`define ETXCS_DEFR_WIN_NS 6400
`define ETXCS_PREAMBLE_NS 6400
`define ETXCS_SQE_GAP_NS 800
`define ETXCS_SQE_WIN_NS 1600
`define ETXCS_LATE_COL_BYTES 64
`define ETXCS_EXCESSIVE_DEFERRAL_BYTES (2 * 1518)
`define ETXCS_MAX_COL 5'd16
`define ETXCS_CNT_MAX 4'hF
`define ETXCS_CYC(ns) (((ns) + `ETXCS_CLK_NS - 1) / `ETXCS_CLK_NS)
`endif

// *** hw/etxcs_pkg.sv ***
/*
 * Types of the transmit control and status block: sequencer states,
 * loop selection, bus request, MAC events, mode outputs and state.
 */
package etxcs_pkg;
    // Transmit sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DEFER = 5'h02,
        ST_SEND = 5'h04,
        ST_SQE_GAP = 5'h08,
        ST_SQE_WIN = 5'h10
    } etxcs_state_e;
    // Where transmit data is looped
    typedef enum logic [1:0] {
        LP_NET = 2'h0,
        LP_ENDEC = 2'h1,
        LP_CORE = 2'h2
    } etxcs_loop_e;
    // Local I/O bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] be;
        logic [3:0] addr;
        logic [15:0] wdata;
    } etxcs_bus_s;
    // Events from the serial MAC core and transceiver
    typedef struct packed {
        logic tx_req;
        logic bcast;
        logic mcast;
        logic carrier;
        logic collision;
        logic tx_end;
        logic sqe;
        logic link_ok;
    } etxcs_ev_s;
    // Effective operating mode towards the core
    typedef struct packed {
        logic fcs;
        logic pad;
        logic skip_defer;
        logic fdx;
        logic coldet;
        logic csmon;
        logic accept_own;
        logic tx_net;
        etxcs_loop_e loop;
    } etxcs_mode_s;
    // Whole state of the block
    typedef struct packed {
        etxcs_state_e st;
        logic [2:0] bank;
        logic [15:0] ctl;
        logic [15:0] stat;
        logic [17:0] cnt;
        logic [17:0] dcnt;
        logic [4:0] ncol;
        logic sqe_seen;
        logic [15:0] ctr;
        logic [15:0] rdata;
        logic go;
        logic jam;
        logic abort;
        logic wb;
        logic [15:0] wbword;
        logic mac_int;
        logic link_int;
        etxcs_mode_s mode;
    } etxcs_state_s;
endpackage : etxcs_pkg

// *** bench/etxcs_phy_model.sv ***
/* Transceiver and cable model: echoes own carrier for a fixed frame,
   pulses end of frame, then raises the quality signal if allowed.
   Assumes tx_go_i comes from the dut, synchronous to mclk_i. */
`timescale 1ns/1ps
module etxcs_phy_model (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic tx_go_i,
    input wire logic sqe_en_i,
    output logic carrier_o,
    output logic tx_end_o,
    output logic sqe_o
);
    // ****************
    // Frame sequencing
    // ****************
    logic [7:0] frm_r; // Frame cycles left
    logic [7:0] gap_r; // Countdown after end of frame
    // Own carrier during the frame; quality pulse mid window
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {carrier_o, tx_end_o, sqe_o, frm_r, gap_r} <= '0;
        end else begin
            tx_end_o <= (frm_r == 8'h01);
            carrier_o <= tx_go_i || (frm_r > 8'h01);
            frm_r <= tx_go_i ? 8'h64 : frm_r - 8'(frm_r != 8'h00);
            gap_r <= (frm_r == 8'h01) ? 8'h8C : gap_r - 8'(gap_r != 8'h00);
            // Held 20 cycles, far from both window edges to avoid races
            sqe_o <= sqe_en_i && (gap_r > 8'h01) && (gap_r < 8'h16);
        end
    end
endmodule : etxcs_phy_model

// *** bench/tb_etxcs_top.sv ***
/* Self-checking bench of the transmit control and status block.
   Assumes the transceiver model beside it and a 100 MHz clock. */
`timescale 1ns/1ps
module tb_etxcs_top;
    // ****************
    // Signals
    // ****************
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic tx_req = 1'b0;
    logic sqe_en = 1'b1;
    logic soft_rst = 1'b0;
    logic link = 1'b1; // Transceiver link state
    logic link_en = 1'b0; // Link change interrupt enable
    logic drop = 1'b0; // Hides carrier and end of frame
    logic coll = 1'b0; // Collision line
    logic car, tend, sqe, go, wb, txen, jam, abrt, irq, lint;
    logic [15:0] rdata, sword;
    etxcs_pkg::etxcs_mode_s mode;
    etxcs_pkg::etxcs_bus_s bus = '0;
    etxcs_pkg::etxcs_ev_s ev;
    int err_count = 0;
    int checks = 0;
    // Broadcast frames; drop keeps a frame running with no carrier
    assign ev = {tx_req, 1'b1, 1'b0, car & ~drop, coll, tend & ~drop, sqe, link};
    always #5 mclk_i = ~mclk_i;
    etxcs_top #(.LATE_COL_CYC(18'd200), .EXCESSIVE_DEFERRAL_CYC(18'd300)) dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .bus_i(bus), .ev_i(ev),
        .link_event_enable_i(link_en), .config_soft_reset_i(soft_rst),
        .rdata_o(rdata), .mode_o(mode), .transmit_enable_o(txen), .tx_go_o(go),
        .jam_o(jam), .abort_o(abrt), .status_wb_o(wb), .status_word_o(sword),
        .mac_core_interrupt_o(irq), .link_int_o(lint));
    etxcs_phy_model phy (.mclk_i(mclk_i), .resetn_i(resetn_i), .tx_go_i(go),
        .sqe_en_i(sqe_en), .carrier_o(car), .tx_end_o(tend), .sqe_o(sqe));
    // ****************
    // Shared tasks
    // ****************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i) bus <= '{1'b1, 1'b0, 2'h3, a, d};
        @(posedge mclk_i) bus.wr <= 1'b0;
    endtask : wr
    // Read data stands from the cycle after the strobe
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_i) bus <= '{1'b0, 1'b1, 2'h3, a, 16'h0000};
        @(posedge mclk_i) bus.rd <= 1'b0;
        @(posedge mclk_i) #1 chk(rdata, e);
    endtask : rd
    task settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : settle
    // One frame; bounded wait for the status copy
    task send(input logic q);
        int n;
        sqe_en <= q;
        tx_req <= 1'b1;
        for (n = 0; n < 3000 && wb !== 1'b1; n++) begin
            @(posedge mclk_i) #1;
            if (go === 1'b1) @(posedge mclk_i) tx_req <= 1'b0;
        end
        chk(16'(wb), 16'h0001);
    endtask : send
    // ****************
    // Scenarios
    // ****************
    task t_bank;
        rd(4'hE, 16'h3300);
        wr(4'hE, 16'h0004);
        wr(4'h0, 16'h0001);
        rd(4'h0, 16'h3333);
        rd(4'hE, 16'h3304);
        wr(4'hE, 16'h0001);
        rd(4'h2, 16'h0000);
        wr(4'hE, 16'h0000);
        rd(4'h0, 16'h0000);
    endtask : t_bank
    task t_modes;
        wr(4'h0, 16'hFFFE);
        rd(4'h0, 16'hBD8E);
        chk(16'({mode.loop, mode.tx_net, mode.fcs}), 16'h0008);
        wr(4'h0, 16'h8002);
        settle;
        chk(16'({mode.loop, mode.tx_net, mode.fdx, mode.csmon}), 16'h000A);
        wr(4'h0, 16'h8400);
        settle;
        chk(16'({mode.coldet, mode.skip_defer, mode.fdx, mode.csmon}), 16'h0006);
        @(posedge mclk_i) soft_rst <= 1'b1;
        @(posedge mclk_i) soft_rst <= 1'b0;
        rd(4'h0, 16'h0000);
    endtask : t_modes
    task t_ok;
        wr(4'h0, 16'h0081);
        send(1'b1);
        chk(sword & 16'h4061, 16'h4041);
        chk(16'(mode.pad), 16'h0001);
    endtask : t_ok
    task t_sqe;
        wr(4'h0, 16'h1001);
        send(1'b0);
        chk(sword & 16'h0021, 16'h0020);
        chk(16'(irq), 16'h0001);
        settle;
        chk(16'(txen), 16'h0000);
    endtask : t_sqe
    // Monitor on, own carrier hidden: abort at end of preamble
    task t_abort;
        wr(4'h0, 16'h0401);
        drop <= 1'b1;
        send(1'b1);
        chk(16'(abrt), 16'h0001);
        chk(sword & 16'h0401, 16'h0400);
        settle;
        chk(16'(txen), 16'h0000);
    endtask : t_abort
    // Collision well past the late limit of 200 cycles
    task t_late;
        wr(4'h0, 16'h0001);
        tx_req <= 1'b1;
        @(posedge go);
        @(posedge mclk_i) tx_req <= 1'b0;
        repeat (250) @(posedge mclk_i);
        coll <= 1'b1;
        @(posedge mclk_i) coll <= 1'b0;
        #1 chk(16'({jam, wb, txen}), 16'h0006);
        chk(sword & 16'h0201, 16'h0200);
    endtask : t_late
    // Link drop with the enable set interrupts and shows in status
    task t_link;
        @(posedge mclk_i) link_en <= 1'b1;
        link <= 1'b0;
        @(posedge mclk_i) #1 chk(16'(lint), 16'h0001);
        rd(4'h2, 16'h0240);
    endtask : t_link
    task test_done;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_bank;
        t_modes;
        t_ok;
        t_sqe;
        t_abort;
        t_late;
        t_link;
        test_done;
    end
    // Tests need about 6000 cycles; 30000 means a hang
    initial begin
        #300000;
        err_count++;
        test_done;
    end
endmodule : tb_etxcs_top
